// >>> hdl/dsag_gate.sv
`timescale 1ns/1ns
module dsag_gate (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic                 extResetActive,
  input  wire logic                 serialClockPin,
  input  wire logic                 padSelectedDebug,
  input  wire logic                 pinMuxEnable,
  input  wire logic                 deviceProtected,
  input  wire logic                 cpuHalted,
  input  wire logic                 guardProtect,
  input  wire logic                 periphClockOn,
  input  wire logic                 highspeedClockOn,
  input  wire logic                 cpuReq,
  input  wire logic                 cpuWrite,
  input  wire logic [3:0]           cpuAddr,
  input  wire logic [31:0]          cpuWdata,
  input  wire logic                 dbgReq,
  input  wire logic                 dbgWrite,
  input  wire logic [3:0]           dbgAddr,
  input  wire logic [31:0]          dbgWdata,
  output logic                      cpuDone,
  output logic [31:0]               cpuRdata,
  output logic                      dbgDone,
  output logic                      dbgError,
  output logic [31:0]               dbgRdata,
  output logic                      cpuResetHold,
  output logic                      padOwnedByUnit,
  output logic                      debuggerPresent
);
  import dsag_pkg::*;

  // =====================================================================
  // state
  logic        rstExt_q,  rstExt_d;
  logic        protErr_q, protErr_d;
  logic        present_q, present_d;
  logic        hotAvail_q, hotAvail_d;
  logic        extRst_q;
  logic        clkPinPrev_q;
  logic [31:0] chan0_q,   chan0_d;
  logic [31:0] chan1_q,   chan1_d;
  logic [31:0] scratch_q, scratch_d;
  logic        cpuPend_q, cpuPend_d;
  logic        dbgPend_q, dbgPend_d;
  logic        cpuWr_q;
  logic        dbgWr_q;
  logic [3:0]  cpuA_q;
  logic [3:0]  dbgA_q;
  logic [31:0] cpuW_q;
  logic [31:0] dbgW_q;
  logic        lastDbg_q, lastDbg_d;
  logic        cpuDone_d, dbgDone_d, dbgErr_d;
  logic [31:0] cpuRdata_d, dbgRdata_d;

  // =====================================================================
  // decode helpers
  function automatic logic [31:0] readWord(input logic [3:0] a, input logic [31:0] st,
                                           input logic [31:0] c0, input logic [31:0] c1,
                                           input logic [31:0] sc);
    logic [31:0] r;
    r = ZeroWord;
    unique case (a)
      RegStatus:    r = st;
      RegChanZero:  r = c0;
      RegChanOne:   r = c1;
      RegScratch:   r = sc;
      RegRomId:     r = RomIdValue;
      RegRomEntry0: r = RomEntry0Val;
      RegRomEntry1: r = RomEntry1Val;
      default:      r = ZeroWord;
    endcase
    return r;
  endfunction : readWord

  // the debugger under protection only reaches status and channel words
  function automatic logic dbgAllowed(input logic [3:0] a, input logic prot);
    return !prot || a == RegStatus || a == RegChanZero || a == RegChanOne;
  endfunction : dbgAllowed

  // =====================================================================
  // arbitration
  wire         busClocksOn = periphClockOn && highspeedClockOn;
  wire         bothPend    = cpuPend_q && dbgPend_q;
  wire         grantDbg    = busClocksOn && dbgPend_q && (!bothPend || !lastDbg_q);
  wire         grantCpu    = busClocksOn && cpuPend_q && !grantDbg;
  wire         srcIsDbg    = grantDbg;
  wire [3:0]   selAddr     = srcIsDbg ? dbgA_q : cpuA_q;
  wire [31:0]  selWdata    = srcIsDbg ? dbgW_q : cpuW_q;
  wire         selWrite    = srcIsDbg ? dbgWr_q : cpuWr_q;
  wire         dbgOk       = dbgAllowed(dbgA_q, deviceProtected);
  wire         isChannel   = selAddr == RegChanZero || selAddr == RegChanOne;
  wire         protBypass  = srcIsDbg || cpuHalted || isChannel;
  wire         wrAllowed   = !guardProtect || protBypass;
  wire         doWrite     = (grantCpu || (grantDbg && dbgOk)) && selWrite && wrAllowed;
  wire [31:0]  statusWord  = {28'h0000000, hotAvail_q, present_q, protErr_q, rstExt_q};
  wire [31:0]  selRead     = readWord(selAddr, statusWord, chan0_q, chan1_q, scratch_q);

  // =====================================================================
  // detection
  wire         resetRelease = extRst_q && !extResetActive;
  wire         coldPlug     = resetRelease && !serialClockPin;
  wire         hotEnable    = hotAvail_q && !deviceProtected && !extResetActive;
  wire         hotPlug      = hotEnable && clkPinPrev_q && !serialClockPin;
  wire         padLost      = !padSelectedDebug || !pinMuxEnable;
  wire         relWrite     = doWrite && selAddr == RegStatus && selWdata[BitRstExt];

  always_comb begin
    rstExt_d   = rstExt_q;
    protErr_d  = protErr_q;
    present_d  = present_q;
    hotAvail_d = hotAvail_q;
    chan0_d    = chan0_q;
    chan1_d    = chan1_q;
    scratch_d  = scratch_q;
    if (relWrite && !deviceProtected) begin
      rstExt_d = 1'b0;
    end
    // clear first so that a refused release in the same write still flags
    if (doWrite && selAddr == RegStatus && selWdata[BitProtErr]) begin
      protErr_d = 1'b0;
    end
    if (relWrite && deviceProtected) begin
      protErr_d = 1'b1;
    end
    if (coldPlug) begin
      rstExt_d = 1'b1;
    end
    if (coldPlug || hotPlug) begin
      present_d = 1'b1;
    end
    if (padLost) begin
      hotAvail_d = 1'b0;
    end else if (extResetActive) begin
      hotAvail_d = 1'b1;
    end
    if (doWrite && selAddr == RegChanZero) begin
      chan0_d = selWdata;
    end
    if (doWrite && selAddr == RegChanOne) begin
      chan1_d = selWdata;
    end
    if (doWrite && selAddr == RegScratch) begin
      scratch_d = selWdata;
    end
  end

  // =====================================================================
  // request capture and answers
  assign cpuPend_d  = grantCpu ? 1'b0 : (cpuPend_q || cpuReq);
  assign dbgPend_d  = grantDbg ? 1'b0 : (dbgPend_q || dbgReq);
  assign lastDbg_d  = grantDbg ? 1'b1 : (grantCpu ? 1'b0 : lastDbg_q);
  assign cpuDone_d  = grantCpu;
  assign dbgDone_d  = grantDbg;
  assign dbgErr_d   = grantDbg && !dbgOk;
  assign cpuRdata_d = (grantCpu && !cpuWr_q) ? selRead : ZeroWord;
  assign dbgRdata_d = (grantDbg && !dbgWr_q && dbgOk) ? selRead : ZeroWord;

  always_ff @(posedge clock) begin
    if (rst) begin
      cpuPend_q <= 1'b0;
      dbgPend_q <= 1'b0;
      lastDbg_q <= 1'b0;
      cpuWr_q   <= 1'b0;
      dbgWr_q   <= 1'b0;
      cpuA_q    <= 4'h0;
      dbgA_q    <= 4'h0;
      cpuW_q    <= ZeroWord;
      dbgW_q    <= ZeroWord;
    end else begin
      cpuPend_q <= cpuPend_d;
      dbgPend_q <= dbgPend_d;
      lastDbg_q <= lastDbg_d;
      if (cpuReq && !cpuPend_q) begin
        cpuWr_q <= cpuWrite;
        cpuA_q  <= cpuAddr;
        cpuW_q  <= cpuWdata;
      end
      if (dbgReq && !dbgPend_q) begin
        dbgWr_q <= dbgWrite;
        dbgA_q  <= dbgAddr;
        dbgW_q  <= dbgWdata;
      end
    end
  end

  // no sleep input: logic keeps running on every rising clock edge it receives
  always_ff @(posedge clock) begin
    if (rst) begin
      rstExt_q        <= 1'b0;
      protErr_q       <= 1'b0;
      present_q       <= 1'b0;
      hotAvail_q      <= 1'b1;
      extRst_q        <= 1'b1;
      clkPinPrev_q    <= 1'b1;
      chan0_q         <= ZeroWord;
      chan1_q         <= ZeroWord;
      scratch_q       <= ZeroWord;
      cpuDone         <= 1'b0;
      dbgDone         <= 1'b0;
      dbgError        <= 1'b0;
      cpuRdata        <= ZeroWord;
      dbgRdata        <= ZeroWord;
      cpuResetHold    <= 1'b0;
      padOwnedByUnit  <= 1'b1;
      debuggerPresent <= 1'b0;
    end else begin
      rstExt_q        <= rstExt_d;
      protErr_q       <= protErr_d;
      present_q       <= present_d;
      hotAvail_q      <= hotAvail_d;
      extRst_q        <= extResetActive;
      clkPinPrev_q    <= serialClockPin;
      chan0_q         <= chan0_d;
      chan1_q         <= chan1_d;
      scratch_q       <= scratch_d;
      cpuDone         <= cpuDone_d;
      dbgDone         <= dbgDone_d;
      dbgError        <= dbgErr_d;
      cpuRdata        <= cpuRdata_d;
      dbgRdata        <= dbgRdata_d;
      cpuResetHold    <= rstExt_d || extResetActive;
      padOwnedByUnit  <= padSelectedDebug && pinMuxEnable;
      debuggerPresent <= present_d;
    end
  end

  // the unit has no interrupt or event ports at all

  // =====================================================================
  // checks
  sequence sColdPlug;
    extRst_q && !extResetActive && !serialClockPin;
  endsequence

  a_cold_plug_hold: assert property (@(posedge clock) disable iff (rst)
    sColdPlug |=> rstExt_q ##1 cpuResetHold)
    else $error("cold plug did not hold cpu in reset");

  a_release_unprot: assert property (@(posedge clock) disable iff (rst)
    relWrite && !deviceProtected && !coldPlug |=> !rstExt_q)
    else $error("release write did not clear extension flag");

  a_release_prot: assert property (@(posedge clock) disable iff (rst)
    relWrite && deviceProtected |=> protErr_q && $stable(rstExt_q))
    else $error("protected release not refused");

  a_hot_plug_seen: assert property (@(posedge clock) disable iff (rst)
    hotPlug |=> present_q ##1 debuggerPresent)
    else $error("hot plug not flagged");

  a_hot_plug_prot: assert property (@(posedge clock) disable iff (rst)
    deviceProtected && !coldPlug && !present_q |=> !present_q)
    else $error("hot plug detected while protected");

  a_pad_lost_hold: assert property (@(posedge clock) disable iff (rst)
    padLost ##1 !extResetActive[*2] |-> !hotAvail_q)
    else $error("hot plug availability returned without reset");

  a_guard_blocks: assert property (@(posedge clock) disable iff (rst)
    grantCpu && cpuWr_q && guardProtect && !cpuHalted && cpuA_q == RegScratch
    |=> $stable(scratch_q))
    else $error("protected cpu write changed register");

  a_channel_free: assert property (@(posedge clock) disable iff (rst)
    grantCpu && cpuWr_q && cpuA_q == RegChanZero |=> chan0_q == $past(cpuW_q))
    else $error("channel write was blocked");

  a_debug_bypass: assert property (@(posedge clock) disable iff (rst)
    grantDbg && dbgWr_q && dbgA_q == RegScratch && !deviceProtected
    |=> scratch_q == $past(dbgW_q))
    else $error("debugger write was blocked");

  a_no_loss: assert property (@(posedge clock) disable iff (rst)
    cpuPend_q && dbgPend_q && busClocksOn |-> ##[1:2] cpuDone)
    else $error("cpu access starved");

endmodule : dsag_gate

// >>> pkg/dsag_pkg.sv
// =====================================================================
// shared constants of the debug service access gate
package dsag_pkg;

  // register index space of the unit (own word map)
  localparam int          RegAw         = 4;
  localparam logic [3:0]  RegStatus     = 4'h0;
  localparam logic [3:0]  RegChanZero   = 4'h1;
  localparam logic [3:0]  RegChanOne    = 4'h2;
  localparam logic [3:0]  RegScratch    = 4'h3;
  localparam logic [3:0]  RegRomId      = 4'h4;
  localparam logic [3:0]  RegRomEntry0  = 4'h5;
  localparam logic [3:0]  RegRomEntry1  = 4'h6;

  // status word field positions
  localparam int          BitRstExt     = 0;
  localparam int          BitProtErr    = 1;
  localparam int          BitDbgPres    = 2;
  localparam int          BitHotAvail   = 3;

  // rom table contents; the identification value is arbitrary
  localparam logic [31:0] RomIdValue    = 32'h00c0_ffee;
  localparam logic [31:0] RomEntry0Val  = 32'h0000_1003;
  localparam logic [31:0] RomEntry1Val  = 32'h0000_2003;
  localparam logic [31:0] ZeroWord      = 32'h0000_0000;

  // bus requesters
  typedef enum logic {
    SrcCpu,
    SrcDebugger
  } dsag_src_t;

endpackage : dsag_pkg

// >>> sim/dsag_probe_model.sv
`timescale 1ns/1ns
// =====================================================================
// debug probe: drives the clock pad and the debugger bus requests
module dsag_probe_model (
  input  wire logic        clock,
  output logic             serialClockPin,
  output logic             dbgReq,
  output logic             dbgWrite,
  output logic [3:0]       dbgAddr,
  output logic [31:0]      dbgWdata,
  input  wire logic        dbgDone,
  input  wire logic        dbgError,
  input  wire logic [31:0] dbgRdata
);
  initial begin
    serialClockPin = 1'b1;
    dbgReq = 1'b0;
    dbgWrite = 1'b0;
    dbgAddr = 4'h0;
    dbgWdata = 32'h0000_0000;
  end

  // low across a reset release asks for the cpu to be held
  task automatic setClock(input logic lvl);
    serialClockPin = lvl;
  endtask : setClock

  task automatic access(input logic wr, input logic [3:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
    rd = 'x;
    err = 'x;
    dbgReq = 1'b1;
    dbgWrite = wr;
    dbgAddr = addr;
    dbgWdata = wd;
    @(posedge clock);
    #1;
    dbgReq = 1'b0;
    // released lines show no stale value
    dbgWrite = ~wr;
    dbgAddr = ~addr;
    dbgWdata = ~wd;
    for (int n = 0; n < 12; n++) begin
      @(posedge clock);
      #1;
      if (dbgDone === 1'b1) begin
        rd = dbgRdata;
        err = dbgError;
        break;
      end
    end
  endtask : access
endmodule : dsag_probe_model

// >>> sim/tb_dsag_gate.sv
`timescale 1ns/1ns
// =====================================================================
// bench of the debug service access gate
module tb_dsag_gate;
  import dsag_pkg::*;
  logic        clock, rst, extResetActive, padSelectedDebug, pinMuxEnable, deviceProtected;
  logic        cpuHalted, guardProtect, periphClockOn, highspeedClockOn, cpuReq, cpuWrite;
  logic [3:0]  cpuAddr, dbgAddr;
  logic [31:0] cpuWdata, dbgWdata, cpuRdata, dbgRdata, rd, dbgRd;
  logic        serialClockPin, dbgReq, dbgWrite, cpuDone, dbgDone, dbgError;
  logic        cpuResetHold, padOwnedByUnit, debuggerPresent, err;
  logic [31:0] pins;
  int          fails = 0, totalChecks = 0, cycles = 0, lat;
  logic [31:0] romExp [4] = '{RomIdValue, RomEntry0Val, RomEntry1Val, ZeroWord};

  assign pins = {29'h0, cpuResetHold, padOwnedByUnit, debuggerPresent};

  dsag_gate i_dut (.clock(clock), .rst(rst), .extResetActive(extResetActive),
    .serialClockPin(serialClockPin), .padSelectedDebug(padSelectedDebug),
    .pinMuxEnable(pinMuxEnable), .deviceProtected(deviceProtected), .cpuHalted(cpuHalted),
    .guardProtect(guardProtect), .periphClockOn(periphClockOn),
    .highspeedClockOn(highspeedClockOn), .cpuReq(cpuReq), .cpuWrite(cpuWrite),
    .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .dbgReq(dbgReq), .dbgWrite(dbgWrite),
    .dbgAddr(dbgAddr), .dbgWdata(dbgWdata), .cpuDone(cpuDone), .cpuRdata(cpuRdata),
    .dbgDone(dbgDone), .dbgError(dbgError), .dbgRdata(dbgRdata), .cpuResetHold(cpuResetHold),
    .padOwnedByUnit(padOwnedByUnit), .debuggerPresent(debuggerPresent));

  dsag_probe_model i_probe (.clock(clock), .serialClockPin(serialClockPin), .dbgReq(dbgReq),
    .dbgWrite(dbgWrite), .dbgAddr(dbgAddr), .dbgWdata(dbgWdata), .dbgDone(dbgDone),
    .dbgError(dbgError), .dbgRdata(dbgRdata));

  always #20 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      finalReport();
    end
  end

  // =====================================================================
  // access tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic cpuAcc(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    rd = 'x;
    lat = 0;
    cpuReq = 1'b1;
    cpuWrite = wr;
    cpuAddr = a;
    cpuWdata = wd;
    step(1);
    cpuReq = 1'b0;
    for (int n = 0; n < 12 && lat == 0; n++) begin
      step(1);
      if (cpuDone === 1'b1) begin
        rd = cpuRdata;
        lat = n + 2;
      end
    end
    chk("cpu done", {31'h0, lat != 0}, 32'h1);
  endtask : cpuAcc

  task automatic cpuExp(input string what, input logic [3:0] a, input logic [31:0] exp);
    cpuAcc(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask : cpuExp

  task automatic dbgAcc(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                        input logic expErr);
    i_probe.access(wr, a, wd, rd, err);
    chk("dbg error", {31'h0, err}, {31'h0, expErr});
  endtask : dbgAcc

  task automatic finalReport();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finalReport

  // =====================================================================
  // test sequence
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    extResetActive = 1'b0;
    deviceProtected = 1'b0;
    cpuHalted = 1'b0;
    guardProtect = 1'b0;
    {padSelectedDebug, pinMuxEnable, periphClockOn, highspeedClockOn} = 4'hf;
    {cpuReq, cpuWrite, cpuAddr, cpuWdata} = '0;
    step(3);
    rst = 1'b0;
    step(1);
    chk("pins", pins, 32'h2);
    cpuExp("status", RegStatus, 32'h8);
    deviceProtected = 1'b1;
    i_probe.setClock(1'b0);
    step(4);
    chk("pins", pins, 32'h2);
    i_probe.setClock(1'b1);
    deviceProtected = 1'b0;
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) padSelectedDebug = 1'b0;
      else pinMuxEnable = 1'b0;
      step(2);
      {padSelectedDebug, pinMuxEnable} = 2'h3;
      step(2);
      cpuExp("status", RegStatus, 32'h0);
      i_probe.setClock(1'b0);
      step(4);
      chk("pins", pins, 32'h2);
      i_probe.setClock(1'b1);
      extResetActive = 1'b1;
      step(3);
      extResetActive = 1'b0;
      step(4);
      chk("pins", pins, 32'h2);
      cpuExp("status", RegStatus, 32'h8);
    end
    i_probe.setClock(1'b0);
    step(4);
    chk("pins", pins, 32'h3);
    cpuExp("status", RegStatus, 32'hc);
    i_probe.setClock(1'b1);
    rst = 1'b1;
    step(3);
    rst = 1'b0;
    $display("test hot plug done");
    extResetActive = 1'b1;
    i_probe.setClock(1'b0);
    step(3);
    extResetActive = 1'b0;
    step(4);
    chk("pins", pins, 32'h7);
    dbgAcc(1'b0, RegStatus, 32'h0, 1'b0);
    chk("status", rd, 32'hd);
    i_probe.setClock(1'b1);
    dbgAcc(1'b1, RegStatus, 32'h0, 1'b0);
    deviceProtected = 1'b1;
    dbgAcc(1'b1, RegStatus, 32'h1, 1'b0);
    step(2);
    chk("pins", pins, 32'h7);
    cpuExp("status", RegStatus, 32'hf);
    deviceProtected = 1'b0;
    dbgAcc(1'b1, RegStatus, 32'h3, 1'b0);
    step(2);
    chk("pins", pins, 32'h3);
    cpuExp("status", RegStatus, 32'hc);
    $display("test cold plug done");
    for (int k = 0; k < 4; k++) cpuExp("rom", RegRomId + 4'(k), romExp[k]);
    cpuAcc(1'b1, RegScratch, 32'h0000_00a1);
    guardProtect = 1'b1;
    deviceProtected = 1'b1;
    dbgAcc(1'b1, RegScratch, 32'h0000_00f0, 1'b1);
    dbgAcc(1'b1, RegChanZero, 32'h0000_00f1, 1'b0);
    deviceProtected = 1'b0;
    cpuAcc(1'b1, RegScratch, 32'h0000_00b2);
    cpuExp("scratch", RegScratch, 32'h0000_00a1);
    for (int k = 1; k < 3; k++) begin
      cpuAcc(1'b1, 4'(k), 32'h0000_00c0 + k);
      cpuExp("channel", 4'(k), 32'h0000_00c0 + k);
    end
    cpuHalted = 1'b1;
    cpuAcc(1'b1, RegScratch, 32'h0000_00d3);
    cpuHalted = 1'b0;
    cpuExp("scratch", RegScratch, 32'h0000_00d3);
    dbgAcc(1'b1, RegScratch, 32'h0000_00e4, 1'b0);
    cpuExp("scratch", RegScratch, 32'h0000_00e4);
    $display("test protection done");
    fork
      cpuAcc(1'b1, RegChanZero, 32'h1111_0000);
      i_probe.access(1'b1, RegChanOne, 32'h0000_2222, dbgRd, err);
    join
    chk("dbg error", {31'h0, err}, 32'h0);
    chk("dbg rdata", dbgRd, ZeroWord);
    cpuExp("channel", RegChanZero, 32'h1111_0000);
    cpuExp("channel", RegChanOne, 32'h0000_2222);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) periphClockOn = 1'b0;
      else highspeedClockOn = 1'b0;
      fork
        cpuAcc(1'b0, RegRomId, 32'h0);
        begin
          step(6);
          {periphClockOn, highspeedClockOn} = 2'h3;
        end
      join
      chk("gated wait", {31'h0, lat >= 6}, 32'h1);
      chk("rom", rd, RomIdValue);
    end
    $display("test arbitration done");
    finalReport();
  end
endmodule : tb_dsag_gate
